// [rtl/ptps_top.sv]
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ns
// How it works
// - seconds wrapping past all ones sets the sticky overflow flag, bit 0.
// - bit 1 reads high while system time is at or past target.
// - pulse frequency under binary rollover is two to the power of the 4-bit rate field.
// - rate zero gives 1 Hz: 125 ms binary, 100 ms digital pulse width.
// - nonzero rates under binary rollover give a 50 percent square wave.
// - reserved bits read zero; status resets to all zeros.
// - reaching target seconds and nanoseconds raises an interrupt.
module ptps_top
    import ptps_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire ptps_time_t system_time_in,
    input wire ptps_target_t target_time_in,
    input wire logic digital_rollover_in,
    output logic pps_out,
    output logic irq_out
);
    // bus data phase tracking
    ptps_dphase_t dphase;
    ptps_dphase_t next_dphase;
    logic dphase_valid;
    logic next_dphase_valid;
    logic [31:0] hrdata;
    logic [31:0] next_hrdata;
    logic accept;
    logic read_accept;
    logic write_commit;
    logic [31:0] read_mux;

    // software registers
    logic [PTPS_RATE_W-1:0] rate;
    logic [PTPS_RATE_W-1:0] next_rate;
    logic [PTPS_EVENT_W-1:0] irq_mask;
    logic [PTPS_EVENT_W-1:0] next_irq_mask;

    // time tracking
    logic [31:0] prev_sec;
    logic [31:0] next_prev_sec;
    logic reached;
    logic next_reached;
    logic at_or_past;
    logic overflow_event;
    logic reached_event;
    logic [PTPS_EVENT_W-1:0] events;

    // status flags
    logic [0:0] overflow_flag;
    logic [0:0] overflow_clear;
    logic [PTPS_EVENT_W-1:0] irq_status;
    logic [PTPS_EVENT_W-1:0] irq_clear;

    // address phase taken while the slave is ready
    always_comb begin
        accept = hsel_in && htrans_in[1] && hready_in && enable_in;
        read_accept = accept && !hwrite_in;
        write_commit = dphase_valid && dphase.write && enable_in;
    end

    // bus phase state
    always_comb begin
        next_dphase = dphase;
        next_dphase_valid = dphase_valid;
        if (hready_in) begin
            next_dphase_valid = accept;
            if (accept) begin
                next_dphase.write = hwrite_in;
                next_dphase.addr = haddr_in[PTPS_DECODE_W-1:0];
            end
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            dphase <= '0;
            dphase_valid <= 1'b0;
        end else if (enable_in) begin
            dphase <= next_dphase;
            dphase_valid <= next_dphase_valid;
        end
    end

    // read multiplexer, sampled in the address phase
    always_comb begin
        read_mux = PTPS_READ_ZERO;
        unique case (haddr_in[PTPS_DECODE_W-1:0])
            PTPS_TIME_STATUS_OFS: begin
                read_mux[PTPS_OVF_BIT] = overflow_flag[0];
                read_mux[PTPS_TGT_BIT] = reached;
            end
            PTPS_PPS_CONTROL_OFS: begin
                read_mux[PTPS_RATE_W-1:0] = rate;
            end
            PTPS_IRQ_STATUS_OFS: begin
                read_mux[PTPS_EVENT_W-1:0] = irq_status;
            end
            PTPS_IRQ_MASK_OFS: begin
                read_mux[PTPS_EVENT_W-1:0] = irq_mask;
            end
            default: begin
                read_mux = PTPS_READ_ZERO;
            end
        endcase
    end

    // read data register
    always_comb begin
        next_hrdata = hrdata;
        if (read_accept) begin
            next_hrdata = read_mux;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            hrdata <= PTPS_READ_ZERO;
        end else if (enable_in) begin
            hrdata <= next_hrdata;
        end
    end

    // software writable registers
    always_comb begin
        next_rate = rate;
        next_irq_mask = irq_mask;
        if (write_commit) begin
            unique case (dphase.addr)
                PTPS_PPS_CONTROL_OFS: begin
                    next_rate = hwdata_in[PTPS_RATE_W-1:0];
                end
                PTPS_IRQ_MASK_OFS: begin
                    next_irq_mask = hwdata_in[PTPS_EVENT_W-1:0];
                end
                default: begin
                    next_rate = rate;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            rate <= PTPS_RATE_RESET;
            irq_mask <= PTPS_IRQ_MASK_RESET;
        end else if (enable_in) begin
            rate <= next_rate;
            irq_mask <= next_irq_mask;
        end
    end

    // time comparison and event detection
    always_comb begin
        at_or_past = (system_time_in.sec > target_time_in.sec) ||
            ((system_time_in.sec == target_time_in.sec) &&
            ({1'b0, system_time_in.subsec} >= target_time_in.nsec));
        overflow_event = (prev_sec == PTPS_SEC_MAX) &&
            (system_time_in.sec == PTPS_SEC_ZERO);
        reached_event = at_or_past && !reached;
        events = '0;
        events[PTPS_OVF_BIT] = overflow_event;
        events[PTPS_TGT_BIT] = reached_event;
        next_prev_sec = system_time_in.sec;
        next_reached = at_or_past;
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            prev_sec <= PTPS_SEC_ZERO;
            reached <= 1'b0;
        end else if (enable_in) begin
            prev_sec <= next_prev_sec;
            reached <= next_reached;
        end
    end

    // clear controls: overflow clears on read, interrupt bits on write-one
    always_comb begin
        overflow_clear = 1'b0;
        irq_clear = '0;
        if (read_accept && (haddr_in[PTPS_DECODE_W-1:0] == PTPS_TIME_STATUS_OFS)) begin
            overflow_clear = 1'b1;
        end
        if (write_commit && (dphase.addr == PTPS_IRQ_STATUS_OFS)) begin
            irq_clear = hwdata_in[PTPS_EVENT_W-1:0];
        end
    end

    ptps_sticky_flag #(
        .WIDTH(1)
    ) u_overflow_flag (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .enable_in(enable_in),
        .set_in(overflow_event),
        .clear_in(overflow_clear),
        .flag_out(overflow_flag)
    );

    ptps_sticky_flag #(
        .WIDTH(PTPS_EVENT_W)
    ) u_irq_status (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .enable_in(enable_in),
        .set_in(events),
        .clear_in(irq_clear),
        .flag_out(irq_status)
    );

    ptps_pps_gen u_pps_gen (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .enable_in(enable_in),
        .subsec_in(system_time_in.subsec),
        .digital_rollover_in(digital_rollover_in),
        .rate_in(rate),
        .pps_out(pps_out)
    );

    // outputs
    assign irq_out = |(irq_status & irq_mask);
    assign hreadyout_out = enable_in;
    assign hresp_out = PTPS_HRESP_OKAY;
    assign hrdata_out = hrdata;
endmodule

// [rtl/ptps_pkg.sv]
package ptps_pkg;
    // register byte offsets
    localparam logic [11:0] PTPS_TIME_STATUS_OFS = 12'h728;
    localparam logic [11:0] PTPS_PPS_CONTROL_OFS = 12'h72C;
    localparam logic [11:0] PTPS_IRQ_STATUS_OFS = 12'h730;
    localparam logic [11:0] PTPS_IRQ_MASK_OFS = 12'h734;
    localparam int PTPS_DECODE_W = 12;

    // field positions
    localparam int PTPS_OVF_BIT = 0;
    localparam int PTPS_TGT_BIT = 1;
    localparam int PTPS_EVENT_W = 2;
    localparam int PTPS_RATE_W = 4;

    // reset values
    localparam logic [31:0] PTPS_TIME_STATUS_RESET = 32'h0000_0000;
    localparam logic [3:0] PTPS_RATE_RESET = 4'h0;
    localparam logic [1:0] PTPS_IRQ_MASK_RESET = 2'h0;
    localparam logic [31:0] PTPS_READ_ZERO = 32'h0000_0000;

    // time and pulse constants
    localparam logic [31:0] PTPS_SEC_MAX = 32'hFFFF_FFFF;
    localparam logic [31:0] PTPS_SEC_ZERO = 32'h0000_0000;
    localparam int PTPS_SUBSEC_W = 31;
    localparam logic [4:0] PTPS_BIN_TOP_BIT = 5'h1E;
    localparam logic [4:0] PTPS_DIG_TOP_BIT = 5'h1D;
    localparam int PTPS_BIN_WIDTH_BITS = 3;
    localparam logic [30:0] PTPS_DIG_WIDTH_NS = 31'h05F5_E100;

    // ahb-lite codes
    localparam logic [1:0] PTPS_HTRANS_NONSEQ = 2'h2;
    localparam logic PTPS_HRESP_OKAY = 1'h0;

    typedef struct packed {
        logic [31:0] sec;
        logic [30:0] subsec;
    } ptps_time_t;

    typedef struct packed {
        logic [31:0] sec;
        logic [31:0] nsec;
    } ptps_target_t;

    typedef struct packed {
        logic write;
        logic [11:0] addr;
    } ptps_dphase_t;
endpackage

// [rtl/ptps_sticky_flag.sv]
`timescale 1ns/1ns
module ptps_sticky_flag
    import ptps_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clear_in,
    output logic [WIDTH-1:0] flag_out
);
    logic [WIDTH-1:0] flag;
    logic [WIDTH-1:0] next_flag;

    // set beats clear in the same cycle
    always_comb begin
        next_flag = (flag & ~clear_in) | set_in;
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            flag <= '0;
        end else if (enable_in) begin
            flag <= next_flag;
        end
    end

    assign flag_out = flag;
endmodule

// [rtl/ptps_pps_gen.sv]
`timescale 1ns/1ns
module ptps_pps_gen
    import ptps_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic [PTPS_SUBSEC_W-1:0] subsec_in,
    input wire logic digital_rollover_in,
    input wire logic [PTPS_RATE_W-1:0] rate_in,
    output logic pps_out
);
    logic pps;
    logic next_pps;
    logic [4:0] bin_bit;
    logic [4:0] dig_bit;

    always_comb begin
        bin_bit = PTPS_BIN_TOP_BIT - {1'b0, rate_in};
        dig_bit = PTPS_DIG_TOP_BIT - {1'b0, rate_in};
        if (rate_in == PTPS_RATE_RESET) begin
            if (digital_rollover_in) begin
                // first 100 ms of each second
                next_pps = subsec_in < PTPS_DIG_WIDTH_NS;
            end else begin
                // first eighth of each second, 125 ms
                next_pps = subsec_in[PTPS_SUBSEC_W-1 -: PTPS_BIN_WIDTH_BITS] == '0;
            end
        end else if (digital_rollover_in) begin
            // nanosecond count is not a power of two, so the wave is irregular
            next_pps = ~subsec_in[dig_bit];
        end else begin
            // half period of 2^rate hz is one subsecond bit
            next_pps = ~subsec_in[bin_bit];
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            pps <= 1'b0;
        end else if (enable_in) begin
            pps <= next_pps;
        end
    end

    assign pps_out = pps;
endmodule

// [testbench/ptps_checker.sv]
`timescale 1ns/1ns
module ptps_checker
    import ptps_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire ptps_time_t system_time_in,
    input wire ptps_target_t target_time_in,
    input wire logic digital_rollover_in,
    input wire logic pps_out,
    input wire logic irq_out
);
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [3:0] rate;
    logic mask_tgt;
    logic sq;
    logic rd_req;
    logic cmp;
    assign rd_req = hsel_in && htrans_in[1] && hready_in && enable_in && !hwrite_in;
    assign cmp = {system_time_in.sec, 1'b0, system_time_in.subsec} >= target_time_in;
    // shadow of rate and target mask from bus writes
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
            rate <= 4'h0;
            mask_tgt <= 1'b0;
            sq <= 1'b0;
        end else begin
            wr_pend <= hsel_in && htrans_in[1] && hready_in && enable_in && hwrite_in;
            wr_addr <= haddr_in[11:0];
            if (wr_pend && wr_addr == 12'h72C) rate <= hwdata_in[3:0];
            if (wr_pend && wr_addr == 12'h734) mask_tgt <= hwdata_in[1];
            sq <= ~system_time_in.subsec[5'h1E - {1'b0, rate}];
        end
    end
    default clocking dc @(posedge clock_in);
    endclocking
    default disable iff (reset_in);
    a_pps_one_hz_bin: assert property (!$past(reset_in) && $past(rate) == 4'h0
        && !$past(digital_rollover_in)
        |-> pps_out == ($past(system_time_in.subsec[30:28]) == 3'h0))
        else $error("binary 1 Hz pulse wrong");
    a_pps_one_hz_dig: assert property (!$past(reset_in) && $past(rate) == 4'h0
        && $past(digital_rollover_in)
        |-> pps_out == ($past(system_time_in.subsec) < 31'h05F5_E100))
        else $error("digital 1 Hz pulse wrong");
    a_pps_square_bin: assert property (!$past(reset_in) && $past(rate) != 4'h0
        && !$past(digital_rollover_in) |-> pps_out == sq)
        else $error("square wave wrong");
    a_status_reached: assert property (rd_req && haddr_in[11:0] == 12'h728
        |=> hrdata_out[1] == $past(cmp, 2))
        else $error("reached flag wrong");
    a_status_ovf_set: assert property (!$past(reset_in) && $past(system_time_in.sec) == 32'hFFFF_FFFF
        && system_time_in.sec == 32'h0000_0000 ##1 rd_req && haddr_in[11:0] == 12'h728
        |=> hrdata_out[0])
        else $error("overflow flag missing");
    a_status_rsv_zero: assert property (rd_req && haddr_in[11:0] == 12'h728
        |=> hrdata_out[31:2] == '0)
        else $error("status reserved bits set");
    a_rate_readback: assert property (rd_req && haddr_in[11:0] == 12'h72C
        |=> hrdata_out == {28'h000_0000, $past(rate)})
        else $error("rate readback wrong");
    a_irq_on_target: assert property (!$past(reset_in) && cmp && !$past(cmp) && mask_tgt
        |=> irq_out)
        else $error("target interrupt missing");
endmodule
bind ptps_top ptps_checker i_ptps_checker (
    .clock_in(clock_in), .reset_in(reset_in), .enable_in(enable_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out), .system_time_in(system_time_in),
    .target_time_in(target_time_in), .digital_rollover_in(digital_rollover_in),
    .pps_out(pps_out), .irq_out(irq_out)
);

// [testbench/ptps_pps_sink.sv]
`timescale 1ns/1ns
module ptps_pps_sink (
    input wire logic clock_in,
    input wire logic clear_in,
    input wire logic pps_in,
    output logic [15:0] rises_out,
    output logic [15:0] high_out
);
    logic last = 1'b0;
    // counts pulse starts and cycles spent high
    always @(posedge clock_in) begin
        if (clear_in) begin
            rises_out <= 16'h0000;
            high_out <= 16'h0000;
        end else begin
            rises_out <= rises_out + 16'(pps_in && !last);
            high_out <= high_out + 16'(pps_in);
        end
        last <= pps_in;
    end
endmodule

// [testbench/ptp_time_status_and_pps_output_tb_top.sv]
`timescale 1ns/1ns
module ptp_time_status_and_pps_output_tb_top;
    import ptps_pkg::*;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic dig = 1'b0;
    logic clear = 1'b1;
    logic rd_pend = 1'b0;
    ptps_time_t sys_time = {32'h0000_0005, 31'h0000_0000};
    ptps_target_t tgt = {32'h0000_000A, 32'h0000_0000};
    logic hreadyout;
    logic pps;
    logic irq;
    logic [31:0] hrdata;
    logic [15:0] rises;
    logic [15:0] highs;
    logic [31:0] exp_q[$];
    int mismatches = 0;
    int comparisons = 0;
    always #5 clock_in = ~clock_in;
    ptps_top i_ptps_top (
        .clock_in(clock_in), .reset_in(reset_in), .enable_in(1'b1), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hreadyout), .hreadyout_out(hreadyout),
        .hresp_out(), .hrdata_out(hrdata), .system_time_in(sys_time),
        .target_time_in(tgt), .digital_rollover_in(dig), .pps_out(pps), .irq_out(irq)
    );
    ptps_pps_sink i_ptps_pps_sink (
        .clock_in(clock_in), .clear_in(clear), .pps_in(pps), .rises_out(rises), .high_out(highs)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        if (!wr) exp_q.push_back(d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0_0000, a};
        do @(posedge clock_in); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock_in); while (hreadyout !== 1'b1);
    endtask
    task automatic sweep(input int n, input logic [30:0] step, input logic [30:0] idle,
        input logic [15:0] rise_exp, input logic [15:0] high_exp);
        sys_time.subsec <= idle;
        clear <= 1'b1;
        tick(3);
        clear <= 1'b0;
        for (int i = 0; i < n; i++) begin
            sys_time.subsec <= 31'(i) * step;
            tick(1);
        end
        tick(3);
        chk({16'h0000, rises}, {16'h0000, rise_exp});
        chk({16'h0000, highs}, {16'h0000, high_exp});
    endtask
    // read data phase result against oldest note
    always @(posedge clock_in) begin
        if (rd_pend) chk(hrdata, exp_q.pop_front());
        rd_pend <= hsel && htrans[1] && !hwrite && hreadyout;
    end
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(74));
        tick(20);
        reset_in <= 1'b0;
        ahb(0, 12'h728, 32'h0000_0000);
        ahb(0, 12'h72C, 32'h0000_0000);
        ahb(0, 12'h734, 32'h0000_0000);
        ahb(1, 12'h7F0, 32'hFFFF_FFFF);
        ahb(0, 12'h7F0, 32'h0000_0000);
        ahb(1, 12'h72C, 32'hFFFF_FFF5);
        ahb(0, 12'h72C, 32'h0000_0005);
        ahb(1, 12'h734, 32'h0000_0001);
        sys_time.sec <= 32'h0000_000A;
        tick(3);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
        ahb(0, 12'h728, 32'h0000_0002);
        ahb(0, 12'h730, 32'h0000_0002);
        ahb(1, 12'h734, 32'h0000_0003);
        tick(1);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0001);
        ahb(1, 12'h730, 32'h0000_0002);
        tick(1);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
        sys_time.sec <= 32'hFFFF_FFFF;
        tick(2);
        sys_time.sec <= 32'h0000_0000;
        tick(1);
        ahb(0, 12'h728, 32'h0000_0001);
        ahb(0, 12'h728, 32'h0000_0000);
        ahb(0, 12'h730, 32'h0000_0001);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0001);
        ahb(1, 12'h730, 32'h0000_0003);
        tick(1);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
        // target reached again with the target bit unmasked
        sys_time.sec <= 32'h0000_000A;
        tick(2);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0001);
        ahb(1, 12'h730, 32'h0000_0003);
        tick(1);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
        for (int r = 0; r < 5; r++) begin
            ahb(1, 12'h72C, 32'(r));
            sweep(32, 31'h0400_0000, 31'h7FFF_FFFF, 16'(1 << r), (r == 0) ? 16'h0004 : 16'h0010);
        end
        for (int r = 0; r < 16; r++) begin
            ahb(1, 12'h72C, 32'(r));
            repeat (40) begin
                sys_time.subsec <= 31'($urandom);
                tick(1);
            end
        end
        ahb(1, 12'h72C, 32'h0000_0000);
        dig <= 1'b1;
        sweep(20, 31'h02FA_F080, 31'h3B9A_C9FF, 16'h0001, 16'h0002);
        repeat (40) begin
            sys_time.subsec <= 31'($urandom % 32'h3B9A_CA00);
            tick(1);
        end
        tally_and_finish();
    end
endmodule
